// *** logic/asicfg_cfg.svh ***
// offsets, codes, reset values and timing counts of the configuration command interpreter
`ifndef ASICFG_CFG_SVH
`define ASICFG_CFG_SVH
`define AC_CMD_MODE  8'h0C
`define AC_CMD_ADDR  8'h0D
`define AC_CMD_PCW   8'h25
`define AC_CMD_PCR   8'h26
`define AC_CMD_ACR   8'h28
`define AC_CMD_LPS   8'h29
`define AC_ERR_OK    7'h00
`define AC_ERR_CMD   7'h01
`define AC_ERR_MODE  7'h02
`define AC_ERR_ADDR  7'h03
`define AC_ERR_ZERO  7'h04
`define AC_ERR_SEG   7'h05
`define AC_ERR_NODE  7'h06
`define AC_FLAG_BIT  7
`define AC_SEG_BIT   0
`define AC_MODE_BIT  0
`define AC_IDX_BAD   6'h20
`define AC_NO_NODE   16'hFFFF
`define AC_CFG_RST   16'hFFFF
`define AC_MODE_RST  1'h0
`define AC_LPS_RST   64'h0
`define AC_LPS_HOLE  64'h0000_0001_0000_0001
`define AC_CLK_NS    40
`define AC_OFF_NS    2000
`define AC_OFF_CYC   ((`AC_OFF_NS + `AC_CLK_NS - 1) / `AC_CLK_NS)
`endif

// *** logic/asicfg_pkg.sv ***
// types shared by the configuration command interpreter
`default_nettype none
package asicfg_pkg;
    typedef enum logic {MODE_PROT, MODE_CONF} asicfg_mode_t;
    typedef enum logic [1:0] {ST_IDLE, ST_MEM, ST_NODE, ST_RESP} asicfg_state_t;
    typedef struct packed {
        logic [7:0]      cmd;
        logic [7:0]      ctl;
        logic [8:0][7:0] pl;
    } asicfg_req_t;
    typedef struct packed {
        logic [7:0]      cmd;
        logic [7:0]      stat;
        logic [1:0][7:0] dat;
    } asicfg_rsp_t;
    typedef struct packed {
        logic [5:0] old_idx;
        logic [5:0] new_idx;
    } asicfg_chg_t;
endpackage
`default_nettype wire

// *** logic/asicfg_mem.sv ***
// projected configuration store, one word per node index, registered read
`timescale 1ns/1ps
`default_nettype none
`include "asicfg_cfg.svh"
module asicfg_mem #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 64,
    parameter int AW    = $clog2(DEPTH)
) (
    input  wire logic             clk,
    input  wire logic             srst,
    input  wire logic             we,
    input  wire logic [AW-1:0]    addr,
    input  wire logic [WIDTH-1:0] wdata,
    output logic [WIDTH-1:0]      rdata
);
    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [WIDTH-1:0] rdata_ff;

    // reset loads the empty image; a real part would reload it from flash here
    always_ff @(posedge clk) begin
        if (srst) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_ff[i] <= WIDTH'(`AC_CFG_RST);
            end
            rdata_ff <= '0;
        end else begin
            if (we) begin
                mem_ff[addr] <= wdata;
            end
            rdata_ff <= mem_ff[addr];
        end
    end

    assign rdata = rdata_ff;
endmodule
`default_nettype wire

// *** logic/asicfg_cmd.sv ***
// command interpreter for node mode, address, configuration and projected list requests
`timescale 1ns/1ps
`default_nettype none
`include "asicfg_cfg.svh"
module asicfg_cmd #(
    parameter logic SEG_SEL = 1'h0
) (
    input  wire logic                    clk,
    input  wire logic                    srst,
    input  wire asicfg_pkg::asicfg_req_t req,
    input  wire logic                    req_valid,
    output logic                         req_ready,
    output var asicfg_pkg::asicfg_rsp_t  rsp,
    output logic                         rsp_valid,
    input  wire logic                    rsp_ready,
    input  wire logic [63:0]             det_list,
    output logic [5:0]                   act_addr,
    input  wire logic [15:0]             act_cfg,
    output var asicfg_pkg::asicfg_chg_t  chg,
    output logic                         chg_req,
    input  wire logic                    chg_ack,
    input  wire logic                    chg_fail,
    input  wire logic                    boot_mode,
    output logic                         nv_mode,
    output logic                         nv_wr,
    output logic [63:0]                  projected_node_list,
    output logic [63:0]                  active_list,
    output logic [63:0]                  cfg_err_list,
    output logic                         cfg_err,
    output logic                         outputs_off
);
    function automatic logic [5:0] node_idx(input logic [7:0] b);
        node_idx = b[5:0];
    endfunction

    function automatic logic bad_idx(input logic [5:0] i);
        bad_idx = (i == `AC_IDX_BAD);
    endfunction

    asicfg_pkg::asicfg_state_t state_ff;
    asicfg_pkg::asicfg_state_t nxt_state;
    asicfg_pkg::asicfg_mode_t  mode_ff;
    asicfg_pkg::asicfg_mode_t  nxt_mode;
    asicfg_pkg::asicfg_mode_t  req_mode;
    asicfg_pkg::asicfg_rsp_t   rsp_ff;
    asicfg_pkg::asicfg_rsp_t   nxt_rsp;
    asicfg_pkg::asicfg_chg_t   chg_ff;
    logic        chg_req_ff;
    logic        boot_ff;
    logic        nv_wr_ff;
    logic        scan_v_ff;
    logic        off_ff;
    logic        cfg_err_ff;
    logic [5:0]  scan_ff;
    logic [5:0]  act_addr_ff;
    logic [5:0]  old_idx;
    logic [5:0]  new_idx;
    logic [5:0]  mem_addr;
    logic [5:0]  off_cnt_ff;
    logic [5:0]  nxt_off_cnt;
    logic [63:0] lps_ff;
    logic [63:0] active_ff;
    logic [63:0] err_ff;
    logic [63:0] lps_new;
    logic [15:0] mem_rdata;
    logic [15:0] chk_cfg;
    logic [6:0]  dec_err;
    logic        accept;
    logic        ok;
    logic        is_conf;
    logic        scan_go;
    logic        mem_we;
    logic        mode_chg;
    logic        off_start;
    logic        det_i;
    logic        lps_i;
    logic        match;
    logic        en_bit;
    logic        err_bit;

    // ---- request decode
    assign req_ready = boot_ff && (state_ff == asicfg_pkg::ST_IDLE);
    assign accept    = req_valid && req_ready;
    assign old_idx   = node_idx(req.pl[0]);
    assign new_idx   = node_idx(req.pl[1]);
    assign req_mode  = asicfg_pkg::asicfg_mode_t'(req.pl[0][`AC_MODE_BIT]);
    assign is_conf   = (mode_ff == asicfg_pkg::MODE_CONF);
    assign ok        = (dec_err == `AC_ERR_OK);
    assign mem_we    = accept && ok && (req.cmd == `AC_CMD_PCW);
    assign mode_chg  = accept && ok && (req.cmd == `AC_CMD_MODE) && (req_mode != mode_ff);
    assign off_start = mode_chg || mem_we;
    // byte 2 of the list payload is reserved; bytes 3..10 hold A then B halves
    assign lps_new   = req.pl[8:1] & ~`AC_LPS_HOLE;

    always_comb begin
        dec_err = `AC_ERR_OK;
        if (req.ctl[`AC_SEG_BIT] != SEG_SEL) begin
            dec_err = `AC_ERR_SEG;
        end else begin
            unique case (req.cmd)
                `AC_CMD_MODE: dec_err = `AC_ERR_OK;
                `AC_CMD_ADDR: begin
                    if (det_list[0] && (old_idx != 6'h00)) begin
                        dec_err = `AC_ERR_ZERO;
                    end else if (bad_idx(old_idx) || bad_idx(new_idx)) begin
                        dec_err = `AC_ERR_ADDR;
                    end else if (!det_list[old_idx] || det_list[new_idx]) begin
                        dec_err = `AC_ERR_ADDR;
                    end
                end
                `AC_CMD_PCW: begin
                    if (!is_conf) begin
                        dec_err = `AC_ERR_MODE;
                    end else if (bad_idx(old_idx)) begin
                        dec_err = `AC_ERR_ADDR;
                    end
                end
                `AC_CMD_PCR,
                `AC_CMD_ACR: begin
                    if (bad_idx(old_idx)) begin
                        dec_err = `AC_ERR_ADDR;
                    end
                end
                `AC_CMD_LPS: dec_err = `AC_ERR_OK;
                default:     dec_err = `AC_ERR_CMD;
            endcase
        end
    end

    // ---- sequencing
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            asicfg_pkg::ST_IDLE: begin
                if (accept) begin
                    if (ok && (req.cmd == `AC_CMD_ADDR)) begin
                        nxt_state = asicfg_pkg::ST_NODE;
                    end else if (ok && (req.cmd == `AC_CMD_PCR || req.cmd == `AC_CMD_ACR)) begin
                        nxt_state = asicfg_pkg::ST_MEM;
                    end else begin
                        nxt_state = asicfg_pkg::ST_RESP;
                    end
                end
            end
            asicfg_pkg::ST_MEM:  nxt_state = asicfg_pkg::ST_RESP;
            asicfg_pkg::ST_NODE: begin
                if (chg_ack) begin
                    nxt_state = asicfg_pkg::ST_RESP;
                end
            end
            asicfg_pkg::ST_RESP: begin
                if (rsp_ready) begin
                    nxt_state = asicfg_pkg::ST_IDLE;
                end
            end
        endcase
    end

    assign chk_cfg = det_list[act_addr_ff] ? act_cfg : `AC_NO_NODE;

    always_comb begin
        nxt_rsp = rsp_ff;
        if (accept) begin
            nxt_rsp.cmd  = req.cmd;
            nxt_rsp.stat = {req.ctl[`AC_FLAG_BIT], dec_err};
            nxt_rsp.dat  = '0;
        end else if (state_ff == asicfg_pkg::ST_MEM) begin
            nxt_rsp.dat = (rsp_ff.cmd == `AC_CMD_ACR) ? chk_cfg : mem_rdata;
        end else if ((state_ff == asicfg_pkg::ST_NODE) && chg_ack && chg_fail) begin
            nxt_rsp.stat[6:0] = `AC_ERR_NODE;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            state_ff <= asicfg_pkg::ST_IDLE;
            rsp_ff   <= '0;
        end else begin
            state_ff <= nxt_state;
            rsp_ff   <= nxt_rsp;
        end
    end

    // ---- mode, persisted; the strap is taken on the first edge after release
    assign nxt_mode = !boot_ff ? asicfg_pkg::asicfg_mode_t'(boot_mode)
                    : mode_chg ? req_mode : mode_ff;

    always_ff @(posedge clk) begin
        if (srst) begin
            mode_ff  <= asicfg_pkg::asicfg_mode_t'(`AC_MODE_RST);
            boot_ff  <= 1'h0;
            nv_wr_ff <= 1'h0;
        end else begin
            mode_ff  <= nxt_mode;
            boot_ff  <= 1'h1;
            nv_wr_ff <= accept && ok && (req.cmd == `AC_CMD_MODE || req.cmd == `AC_CMD_PCW
                                      || req.cmd == `AC_CMD_LPS);
        end
    end

    // ---- projected list, only touched by an accepted list write
    always_ff @(posedge clk) begin
        if (srst) begin
            lps_ff <= `AC_LPS_RST;
        end else if (accept && ok && (req.cmd == `AC_CMD_LPS)) begin
            lps_ff <= lps_new;
        end
    end

    // ---- address change hand-off to the node side; held until acknowledged
    always_ff @(posedge clk) begin
        if (srst) begin
            chg_req_ff <= 1'h0;
            chg_ff     <= '0;
        end else if (accept && ok && (req.cmd == `AC_CMD_ADDR)) begin
            chg_req_ff <= 1'h1;
            chg_ff     <= '{old_idx: old_idx, new_idx: new_idx};
        end else if (chg_ack) begin
            chg_req_ff <= 1'h0;
        end
    end

    // ---- offline phase: outputs dark for a fixed time
    assign nxt_off_cnt = off_start ? 6'(`AC_OFF_CYC)
                       : (off_cnt_ff != 6'h00) ? off_cnt_ff - 6'h01 : 6'h00;

    always_ff @(posedge clk) begin
        if (srst) begin
            off_cnt_ff <= 6'h00;
            off_ff     <= 1'h0;
        end else begin
            off_cnt_ff <= nxt_off_cnt;
            off_ff     <= (nxt_off_cnt != 6'h00);
        end
    end

    // ---- background scan over all node indices, one per idle cycle.
    // the shared store port is lent to commands, so a list update lags by up to one sweep
    assign scan_go  = req_ready && !accept;
    assign mem_addr = scan_go ? scan_ff : old_idx;
    assign det_i    = det_list[act_addr_ff];
    assign lps_i    = lps_ff[act_addr_ff];
    assign match    = (mem_rdata == act_cfg);
    assign en_bit   = det_i && (is_conf ? (act_addr_ff[4:0] != 5'h00)
                                        : (lps_i && match));
    assign err_bit  = lps_i ? !(det_i && match) : det_i;

    always_ff @(posedge clk) begin
        if (srst) begin
            scan_ff     <= 6'h00;
            scan_v_ff   <= 1'h0;
            act_addr_ff <= 6'h00;
        end else begin
            scan_ff     <= scan_go ? scan_ff + 6'h01 : scan_ff;
            scan_v_ff   <= scan_go;
            act_addr_ff <= mem_addr;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            active_ff <= '0;
            err_ff    <= '0;
        end else if (off_ff) begin
            active_ff <= '0;
        end else if (scan_v_ff) begin
            active_ff[act_addr_ff] <= en_bit;
            err_ff[act_addr_ff]    <= err_bit;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            cfg_err_ff <= 1'h0;
        end else begin
            cfg_err_ff <= |err_ff;
        end
    end

    asicfg_mem #(
        .WIDTH (16),
        .DEPTH (64)
    ) u_store (
        .clk   (clk),
        .srst  (srst),
        .we    (mem_we),
        .addr  (mem_addr),
        .wdata ({req.pl[1], req.pl[2]}),
        .rdata (mem_rdata)
    );

    assign rsp                 = rsp_ff;
    assign rsp_valid           = (state_ff == asicfg_pkg::ST_RESP);
    assign act_addr            = act_addr_ff;
    assign chg                 = chg_ff;
    assign chg_req             = chg_req_ff;
    assign nv_mode             = mode_ff;
    assign nv_wr               = nv_wr_ff;
    assign projected_node_list = lps_ff;
    assign active_list         = active_ff;
    assign cfg_err_list        = err_ff;
    assign cfg_err             = cfg_err_ff;
    assign outputs_off         = off_ff;

    // ---- checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    a_mode_taken: assert property (
        accept && ok && req.cmd == `AC_CMD_MODE |=> mode_ff == $past(req_mode))
        else $error("mode not taken from payload bit 0");
    a_prot_gate: assert property (
        scan_v_ff && !off_ff && !is_conf && !(det_i && lps_i && match)
        |=> !active_ff[$past(act_addr_ff)])
        else $error("protected mode enabled a node it must not");
    a_zero_dark: assert property (!active_ff[0] && !active_ff[32])
        else $error("node at address 0 enabled");
    a_err_raise: assert property (
        scan_v_ff && !off_ff && lps_i && det_i && !match |=> ##1 cfg_err_ff)
        else $error("mismatch did not raise configuration error");
    a_off_hold: assert property (off_start |=> off_ff [*8])
        else $error("offline phase too short");
    a_off_dark: assert property (off_ff |=> active_ff == 64'h0)
        else $error("outputs active during offline phase");
    a_rsp_echo: assert property (
        accept |=> rsp_ff.cmd == $past(req.cmd) && rsp_ff.stat[7] == $past(req.ctl[7]))
        else $error("response header does not echo request");
    a_zero_refuse: assert property (
        accept && req.cmd == `AC_CMD_ADDR && det_list[0] && |old_idx && req.ctl[0] == SEG_SEL
        |=> !chg_req_ff && rsp_ff.stat[6:0] == `AC_ERR_ZERO)
        else $error("address change ran with node at address 0");
    a_pcw_mode: assert property (
        accept && req.cmd == `AC_CMD_PCW && !is_conf |-> !mem_we ##1 rsp_ff.stat[6:0] != 7'h00)
        else $error("configuration write taken outside configuration mode");
    a_no_node: assert property (
        state_ff == asicfg_pkg::ST_MEM && rsp_ff.cmd == `AC_CMD_ACR && !det_i
        |=> rsp_ff.dat == `AC_NO_NODE)
        else $error("absent node not reported as all 0xF");
    a_reject_keep: assert property (
        accept && !ok |=> $stable(lps_ff) && $stable(mode_ff) && rsp_ff.stat[6:0] != 7'h00)
        else $error("refused command changed stored state");
    a_lps_load: assert property (
        accept && ok && req.cmd == `AC_CMD_LPS |=> lps_ff == $past(lps_new) && !lps_ff[0])
        else $error("projected list not loaded as laid out");

    c_mode_swap: cover property (mode_chg ##1 off_ff);
    c_cfg_write: cover property (mem_we ##[1:60] rsp_valid && rsp_ready);
    c_addr_chg:  cover property (chg_req_ff ##[1:20] chg_ack);
    c_act_read:  cover property (state_ff == asicfg_pkg::ST_MEM && rsp_ff.cmd == `AC_CMD_ACR);
endmodule
`default_nettype wire

// *** sim/asicfg_node_model.sv ***
// node population model: presence, actual configuration and address moves
`timescale 1ns/1ps
`default_nettype none
module asicfg_node_model (
    input  wire logic                    clk,
    input  wire logic                    srst,
    input  wire logic [5:0]              act_addr,
    output logic [15:0]                  act_cfg,
    output logic [63:0]                  det_list,
    input  wire asicfg_pkg::asicfg_chg_t chg,
    input  wire logic                    chg_req,
    output logic                         chg_ack,
    output logic                         chg_fail,
    input  wire logic                    slow,
    input  wire logic                    fail_next
);
    logic [15:0] cfg_ff [64];
    logic [7:0]  tick_ff;
    logic [3:0]  wait_ff;

    // absent node: moving pattern that never reads as all ones, so a missing default shows
    assign act_cfg = det_list[act_addr] ? cfg_ff[act_addr] : {tick_ff, ~tick_ff};

    task automatic set_node(input int idx, input logic [15:0] cfg, input logic here);
        cfg_ff[idx] = cfg;
        det_list[idx] = here;
    endtask

    initial begin
        det_list = '0;
        tick_ff = '0;
        wait_ff = '0;
        chg_ack = 1'b0;
        chg_fail = 1'b0;
    end

    always @(posedge clk) begin
        tick_ff <= tick_ff + 8'h1;
        chg_ack <= 1'b0;
        // fail line means nothing outside the acknowledge, so it wanders
        chg_fail <= tick_ff[0];
        if (srst) begin
            wait_ff <= '0;
        end else if (chg_req && !chg_ack) begin
            if (wait_ff == (slow ? 4'h6 : 4'h0)) begin
                chg_ack <= 1'b1;
                chg_fail <= fail_next;
                wait_ff <= '0;
                if (!fail_next) begin
                    det_list[chg.old_idx] <= 1'b0;
                    det_list[chg.new_idx] <= 1'b1;
                    cfg_ff[chg.new_idx] <= cfg_ff[chg.old_idx];
                end
            end else begin
                wait_ff <= wait_ff + 4'h1;
            end
        end
    end
endmodule
`default_nettype wire

// *** sim/asicfg_cmd_tb.sv ***
// self-checking bench of the configuration command interpreter
`timescale 1ns/1ps
`default_nettype none
`include "asicfg_cfg.svh"
module asicfg_cmd_tb;
    logic clk, srst, req_valid, rsp_ready, boot_mode, slow, fail_next;
    logic req_ready, rsp_valid, chg_req, chg_ack, chg_fail, nv_mode, nv_wr, cfg_err, outputs_off;
    asicfg_pkg::asicfg_req_t req;
    asicfg_pkg::asicfg_rsp_t rsp, got;
    asicfg_pkg::asicfg_chg_t chg;
    logic [5:0]  act_addr;
    logic [15:0] act_cfg;
    logic [63:0] det_list, projected_node_list, active_list, cfg_err_list;
    logic [15:0] store_m [64];
    logic [15:0] cfg_m [64];
    logic [63:0] det_m, lps_m, exp_act, exp_err, v;
    logic [8:0][7:0] pl;
    int num_errors, checks, seed, i, o, w;

    asicfg_cmd DUT (.clk, .srst, .req, .req_valid, .req_ready, .rsp, .rsp_valid, .rsp_ready,
        .det_list, .act_addr, .act_cfg, .chg, .chg_req, .chg_ack, .chg_fail, .boot_mode,
        .nv_mode, .nv_wr, .projected_node_list, .active_list, .cfg_err_list, .cfg_err,
        .outputs_off);
    asicfg_node_model NODE (.clk, .srst, .act_addr, .act_cfg, .det_list, .chg, .chg_req,
        .chg_ack, .chg_fail, .slow, .fail_next);

    always #20 clk = ~clk;

    task automatic check(input logic [63:0] g, input logic [63:0] e, input string what);
        checks++;
        if (g !== e) begin
            num_errors++;
            $display("ERROR %0t %s got %h exp %h", $time, what, g, e);
        end
    endtask

    task automatic print_verdict();
        if (num_errors == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic send(input logic [7:0] cmd, input logic seg, input logic [6:0] err);
        int n;
        logic flag;
        logic wr;
        logic wr_exp;
        @(posedge clk);
        #1;
        flag = 1'($random(seed));
        wr_exp = (err == `AC_ERR_OK)
                 && (cmd == `AC_CMD_MODE || cmd == `AC_CMD_PCW || cmd == `AC_CMD_LPS);
        req = {cmd, flag, 6'h00, seg, pl};
        req_valid = 1'b1;
        n = 0;
        // ready is looked at once settled, so the next edge is the one that takes the request
        while (req_ready !== 1'b1 && n < 200) begin
            @(posedge clk);
            #1;
            n++;
        end
        @(posedge clk);
        #1;
        wr = nv_wr;
        req_valid = 1'b0;
        // released request shows the inverse, so nothing may lean on stale bytes
        req = ~req;
        n = 0;
        while (rsp_valid !== 1'b1 && n < 400) begin
            @(posedge clk);
            #1;
            n++;
        end
        got = rsp;
        rsp_ready = 1'b1;
        @(posedge clk);
        #1;
        rsp_ready = 1'b0;
        check(n < 400, 1, "response wait");
        check(got.cmd, cmd, "echoed command");
        check(got.stat, {flag, err}, "flag and error code");
        check(wr, wr_exp, "store write pulse");
    endtask

    task automatic scan_check();
        repeat (140) @(posedge clk);
        #1;
        exp_err = '0;
        for (int k = 0; k < 64; k++) begin
            exp_err[k] = (lps_m[k] && !(det_m[k] && store_m[k] == cfg_m[k]))
                         || (det_m[k] && !lps_m[k]);
        end
        check(cfg_err_list, exp_err, "error list");
        check(cfg_err, |exp_err, "error summary");
        check(active_list, exp_act, "active list");
    endtask

    initial begin
        #(40 * 20000);
        num_errors++;
        print_verdict();
    end

    initial begin
        seed = 88160;
        clk = 0;
        srst = 1;
        req = '0;
        req_valid = 0;
        rsp_ready = 0;
        boot_mode = 1;
        slow = 0;
        fail_next = 0;
        num_errors = 0;
        checks = 0;
        det_m = '0;
        for (i = 0; i < 64; i++) begin
            store_m[i] = 16'hFFFF;
            cfg_m[i] = 16'($random(seed));
        end
        for (w = 0; w < 10; w++) begin
            i = {$random(seed)} % 62 + 1;
            i = (i >= 32) ? i + 1 : i;
            det_m[i] = 1'b1;
            NODE.set_node(i, cfg_m[i], 1'b1);
        end
        repeat (12) @(posedge clk);
        #1;
        srst = 0;
        repeat (3) @(posedge clk);
        #1;
        check(nv_mode, 1'b1, "boot mode");
        pl = '0;
        send(8'h7E, 1'b0, `AC_ERR_CMD);
        send(`AC_CMD_PCR, 1'b1, `AC_ERR_SEG);
        for (i = 0; i < 64; i++) begin
            pl[0] = 8'(i);
            send(`AC_CMD_ACR, 1'b0, (i == 32) ? `AC_ERR_ADDR : `AC_ERR_OK);
            if (i != 32) check(got.dat, det_m[i] ? cfg_m[i] : 16'hFFFF, "actual");
        end
        for (i = 0; i < 64; i++) begin
            if (det_m[i]) begin
                w = ($random(seed) & 1) ? cfg_m[i] : cfg_m[i] ^ 16'h0100;
                pl[0] = 8'(i);
                pl[1] = w[15:8];
                pl[2] = w[7:0];
                send(`AC_CMD_PCW, 1'b0, `AC_ERR_OK);
                store_m[i] = 16'(w);
                check(outputs_off, 1'b1, "outputs off on write");
            end
        end
        for (i = 0; i < 64; i++) begin
            pl[0] = 8'(i);
            send(`AC_CMD_PCR, 1'b0, (i == 32) ? `AC_ERR_ADDR : `AC_ERR_OK);
            if (i != 32) check(got.dat, store_m[i], "stored config");
        end
        v = {$random(seed), $random(seed)};
        for (i = 1; i < 9; i++) pl[i] = v[8*(i-1) +: 8];
        send(`AC_CMD_LPS, 1'b0, `AC_ERR_OK);
        lps_m = v & ~`AC_LPS_HOLE;
        check(projected_node_list, lps_m, "projected list");
        NODE.set_node(0, cfg_m[0], 1'b1);
        det_m[0] = 1'b1;
        exp_act = det_m & ~64'h1;
        scan_check();
        for (o = 63; o > 0 && !det_m[o]; o--) ;
        for (w = 1; det_m[w] || w == 32; w++) ;
        pl = '0;
        pl[0] = 8'(o);
        pl[1] = 8'(w);
        send(`AC_CMD_ADDR, 1'b0, `AC_ERR_ZERO);
        NODE.set_node(0, cfg_m[0], 1'b0);
        det_m[0] = 1'b0;
        pl = '0;
        send(`AC_CMD_MODE, 1'b0, `AC_ERR_OK);
        check(nv_mode, 1'b0, "protected mode");
        check(outputs_off, 1'b1, "outputs off on mode");
        exp_act = '0;
        for (i = 0; i < 64; i++) exp_act[i] = lps_m[i] && det_m[i] && store_m[i] == cfg_m[i];
        scan_check();
        pl[0] = 8'(o);
        pl[1] = 8'h5A;
        send(`AC_CMD_PCW, 1'b0, `AC_ERR_MODE);
        send(`AC_CMD_PCR, 1'b0, `AC_ERR_OK);
        check(got.dat, store_m[o], "store kept");
        pl[1] = 8'(w);
        fail_next = 1;
        send(`AC_CMD_ADDR, 1'b0, `AC_ERR_NODE);
        fail_next = 0;
        slow = 1;
        send(`AC_CMD_ADDR, 1'b0, `AC_ERR_OK);
        cfg_m[w] = cfg_m[o];
        pl[0] = 8'(w);
        send(`AC_CMD_ACR, 1'b0, `AC_ERR_OK);
        check(got.dat, cfg_m[o], "moved node");
        pl[0] = 8'(o);
        send(`AC_CMD_ACR, 1'b0, `AC_ERR_OK);
        check(got.dat, 16'hFFFF, "vacated address");
        // restart from protected mode: the strap must bring configuration mode back
        srst = 1'b1;
        repeat (12) @(posedge clk);
        #1;
        check(req_ready, 1'b0, "busy in reset");
        srst = 1'b0;
        repeat (3) @(posedge clk);
        #1;
        check(nv_mode, 1'b1, "restored mode");
        check(projected_node_list, `AC_LPS_RST, "list after restart");
        pl[0] = 8'(w);
        send(`AC_CMD_PCW, 1'b0, `AC_ERR_OK);
        check(outputs_off, 1'b1, "outputs off after restart");
        print_verdict();
    end
endmodule
`default_nettype wire
